// ===== bench/fpc_controller_tb.sv
// self-checking bench for the flash programming controller
`timescale 1ns/100ps
`default_nettype none
module fpc_controller_tb;
    typedef struct {logic [7:0] ofs; logic [31:0] wr; logic [31:0] rst;
        logic [31:0] rd;} fpc_row_s;
    localparam logic [31:0] UID1 = 32'h0A0A_0002;
    localparam logic [31:0] MID = 32'h0000_00C3;
    logic clock = 0, reset = 1, reg_write = 0, reg_read = 0, key_write = 0;
    logic cold_reset = 1, running_from_loader = 0, slow = 0;
    logic [7:0] reg_address = 8'h00, key_byte = 8'h00;
    logic [31:0] reg_write_data = 32'h0, d;
    logic [1:0] boot_select_cfg = 2'b11, flash_op, req_op;
    logic [31:0] reg_read_data, flash_address, flash_write_data, flash_read_data, req_addr, req_wd;
    logic protect_unlocked, flash_request, flash_done, low_freq_optimisation;
    logic [11:0] vector_remap_page;
    int num_errors = 0, checks_done = 0, cycles = 0, req_count = 0;
    // boot field 11: boot bit resets to 0, status mirrors 11 in bits 2:1
    fpc_row_s rows [8] = '{'{8'h00, 32'h79, 0, 32'h39}, '{8'h04, 32'hFFFF_FFFC, 0, 32'hFFFF_FFFC},
        '{8'h08, 32'hA5A5_5A5A, 0, 32'hA5A5_5A5A}, '{8'h0C, 32'hFFFF_FFE1, 0, 32'h21},
        '{8'h14, 32'hFFFF_FFFF, 32'h0001_F000, 32'h0001_F000}, '{8'h18, 32'hFFFF_FFFF, 0, 32'h10},
        '{8'h20, 32'hFFFF_FFFF, 0, 0}, '{8'h40, 32'hFFFF_FFFF, 32'h6, 32'h6}};
    always #25 clock = ~clock;
    // id values are arbitrary
    fpc_controller #(.MAKER_ID(MID), .UNIQUE_ID0(32'h0A0A_0001), .UNIQUE_ID1(UID1),
        .UNIQUE_ID2(32'h0A0A_0003)) uut (.clock, .reset, .reg_address, .reg_write_data,
        .reg_write, .reg_read, .reg_read_data, .key_write, .key_byte, .protect_unlocked,
        .cold_reset, .boot_select_cfg, .running_from_loader, .flash_request, .flash_op,
        .flash_address, .flash_write_data, .flash_done, .flash_read_data, .vector_remap_page,
        .low_freq_optimisation);
    fpc_flash_model flash (.clock, .reset, .slow, .flash_request, .flash_op, .flash_address,
        .flash_write_data, .flash_done, .flash_read_data);
    always @(posedge clock) begin
        if (flash_request) begin
            req_count <= req_count + 1;
            req_op <= flash_op;
            req_addr <= flash_address;
            req_wd <= flash_write_data;
        end
    end
    task test_done();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_address <= a;
        reg_write_data <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_address <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        v = reg_read_data;
    endtask
    task send_keys(input logic [23:0] k);
        for (int i = 2; i >= 0; i--) begin
            @(posedge clock);
            key_write <= 1'b1;
            key_byte <= k[i*8+:8];
        end
        @(posedge clock);
        key_write <= 1'b0;
        @(negedge clock);
    endtask
    task run_op(input logic [31:0] ctl, input logic [5:0] cmd, input logic [31:0] adr,
            input logic [31:0] wd, input logic req, input logic fail);
        int n;
        int base;
        reg_wr(8'h00, ctl);
        reg_wr(8'h04, adr);
        reg_wr(8'h08, wd);
        reg_wr(8'h0C, {26'h0, cmd});
        base = req_count;
        reg_wr(8'h10, 32'h1);
        if (slow) begin
            reg_rd(8'h40, d);
            check(d[0], 1, "busy in status");
        end
        n = 0;
        do begin
            reg_rd(8'h10, d);
            n++;
        end while (d[0] === 1'b1 && n < 100);
        check(d, 0, "trigger self clear");
        check(req_count != base, req, "flash started");
        reg_rd(8'h00, d);
        check(d[6], fail, "fail flag");
        reg_rd(8'h40, d);
        check(d[6], fail, "status fail flag");
        reg_wr(8'h40, 32'h40);
        reg_rd(8'h00, d);
        check(d[6], 0, "fail clear");
    endtask
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        foreach (rows[i]) begin
            reg_rd(rows[i].ofs, d);
            check(d, rows[i].rst, "reset value");
        end
        $display("test reset values done");
        reg_wr(8'h00, 32'h39);
        reg_wr(8'h18, 32'h10);
        reg_wr(8'h10, 32'h1);
        reg_rd(8'h00, d);
        check(d, 0, "locked control");
        reg_rd(8'h18, d);
        check(d, 0, "locked access bit");
        check(req_count, 0, "locked trigger");
        send_keys(24'h165988);
        check(protect_unlocked, 0, "wrong key order");
        send_keys(24'h591688);
        check(protect_unlocked, 1, "unlock");
        $display("test protection done");
        foreach (rows[i]) begin
            reg_wr(rows[i].ofs, rows[i].wr);
            reg_rd(rows[i].ofs, d);
            check(d, rows[i].rd, "write readback");
        end
        $display("test register table done");
        slow = 1'b1;
        run_op(32'h39, 6'h21, 32'h100, 32'hCAFE_F00D, 1, 0);
        check(req_op, 2'h1, "program op");
        check(req_addr, 32'h100, "program address");
        check(req_wd, 32'hCAFE_F00D, "program word");
        slow = 1'b0;
        run_op(32'h39, 6'h00, 32'h100, 32'h0, 1, 0);
        reg_rd(8'h08, d);
        check(d, 32'hCAFE_F00D, "read back word");
        run_op(32'h39, 6'h22, 32'h0, 32'h0, 1, 0);
        check(req_op, 2'h2, "erase op");
        run_op(32'h39, 6'h00, 32'h100, 32'h0, 1, 0);
        reg_rd(8'h08, d);
        check(d, 32'hFFFF_FFFF, "erased word");
        run_op(32'h39, 6'h04, 32'h4, 32'h0, 0, 0);
        reg_rd(8'h08, d);
        check(d, UID1, "unique id");
        run_op(32'h39, 6'h0B, 32'h0, 32'h0, 0, 0);
        reg_rd(8'h08, d);
        check(d, MID, "maker id");
        run_op(32'h39, 6'h2E, 32'h8000, 32'h0, 0, 0);
        reg_rd(8'h40, d);
        check(d, 32'h8006, "remap status");
        check(vector_remap_page, 12'h040, "remap page port");
        run_op(32'h39, 6'h21, 32'h0030_0000, 32'h1, 1, 0);
        run_op(32'h39, 6'h21, 32'h0010_0000, 32'h1, 1, 0);
        $display("test commands done");
        run_op(32'h31, 6'h21, 32'h200, 32'h1, 0, 1);
        run_op(32'h19, 6'h21, 32'h0010_0000, 32'h1, 0, 1);
        run_op(32'h29, 6'h21, 32'h0030_0000, 32'h1, 0, 1);
        run_op(32'h39, 6'h21, 32'h0020_0000, 32'h1, 0, 1);
        run_op(32'h38, 6'h21, 32'h100, 32'h1, 0, 1);
        @(posedge clock);
        running_from_loader <= 1'b1;
        run_op(32'h39, 6'h21, 32'h0010_0004, 32'h1, 0, 1);
        $display("test refusals done");
        reg_wr(8'h00, 32'h3B);
        reg_rd(8'h00, d);
        check(d, 32'h3B, "boot select write");
        // first a warm reset that keeps boot select, then a cold one that reloads it
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            cold_reset <= k[0];
            repeat (3) @(posedge clock);
            reset <= 1'b1;
            repeat (6) @(posedge clock);
            reset <= 1'b0;
            reg_rd(8'h00, d);
            check(d, k ? 32'h0 : 32'h2, "boot select after reset");
        end
        check(protect_unlocked, 0, "relocked by reset");
        $display("test resets done");
        test_done();
    end
endmodule
`default_nettype wire

// ===== bench/fpc_flash_model.sv
// behavioural flash array behind the controller, prompt or slow
`timescale 1ns/100ps
`default_nettype none
module fpc_flash_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic slow,
    input wire logic flash_request,
    input wire logic [1:0] flash_op,
    input wire logic [31:0] flash_address,
    input wire logic [31:0] flash_write_data,
    output logic flash_done,
    output logic [31:0] flash_read_data
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] word_q = 32'h0;
    int wait_q = 0;
    int hold_q = 0;
    // word only valid while done and two cycles after; otherwise inverted so no stale match
    assign flash_read_data = (hold_q > 0) ? word_q : ~word_q;
    always @(posedge clock) begin
        if (reset) begin
            wait_q <= 0;
            hold_q <= 0;
            flash_done <= 1'b0;
        end else if (flash_request) begin
            wait_q <= slow ? 24 : 1;
            word_q <= mem.exists(flash_address) ? mem[flash_address] : 32'hFFFF_FFFF;
            if (flash_op == 2'h1)
                mem[flash_address] = flash_write_data;
            if (flash_op == 2'h2)
                for (int i = 0; i < 128; i++)
                    mem.delete({flash_address[31:9], i[6:0], 2'b00});
        end else if (wait_q == 1) begin
            wait_q <= 0;
            hold_q <= 6;
            flash_done <= 1'b1;
        end else if (wait_q > 1) begin
            wait_q <= wait_q - 1;
        end else if (hold_q > 0) begin
            hold_q <= hold_q - 1;
            flash_done <= hold_q > 3;
        end
    end
endmodule
`default_nettype wire

// ===== bench/fpc_properties.sv
// concurrent checks on the flash programming controller ports
`timescale 1ns/100ps
`default_nettype none
module fpc_properties (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] reg_address,
    input wire logic [31:0] reg_write_data,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_read_data,
    input wire logic key_write,
    input wire logic [7:0] key_byte,
    input wire logic protect_unlocked,
    input wire logic flash_request,
    input wire logic [1:0] flash_op,
    input wire logic [31:0] flash_address,
    input wire logic [11:0] vector_remap_page,
    input wire logic low_freq_optimisation
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    sequence key_run_s;
        key_write && key_byte == 8'h59 ##1 key_write && key_byte == 8'h16
            ##1 key_write && key_byte == 8'h88;
    endsequence
    sequence read_at_s(logic [7:0] ofs);
        reg_read && reg_address == ofs;
    endsequence
    sequence lfo_write_s;
        reg_write && reg_address == 8'h18;
    endsequence
    unlock_opens_a: assert property (key_run_s |=> protect_unlocked)
        else $error("unlock keys did not open protection");
    request_pulse_a: assert property (flash_request |=> !flash_request)
        else $error("flash request longer than one cycle");
    word_aligned_a: assert property (flash_request |-> flash_address[1:0] == 2'b00)
        else $error("flash address not word aligned");
    op_legal_a: assert property (flash_request |-> flash_op != 2'h3)
        else $error("flash operation code out of range");
    lfo_locked_a: assert property (lfo_write_s and !protect_unlocked |=>
        $stable(low_freq_optimisation)) else $error("locked write changed access bit");
    lfo_open_a: assert property (lfo_write_s and protect_unlocked |=>
        low_freq_optimisation == $past(reg_write_data[4])) else $error("access bit not written");
    dfbase_fixed_a: assert property (read_at_s(8'h14) |=> reg_read_data == 32'h0001_F000)
        else $error("data flash base wrong");
    unmapped_zero_a: assert property (read_at_s(8'h20) |=> reg_read_data == 32'h0)
        else $error("unmapped read not zero");
    remap_status_a: assert property (read_at_s(8'h40) |=>
        reg_read_data[20:9] == $past(vector_remap_page) && reg_read_data[31:21] == 11'h0)
        else $error("status remap field wrong");
endmodule
bind fpc_controller fpc_properties chk (.clock, .reset, .reg_address, .reg_write_data,
    .reg_write, .reg_read, .reg_read_data, .key_write, .key_byte, .protect_unlocked,
    .flash_request, .flash_op, .flash_address, .vector_remap_page, .low_freq_optimisation);
`default_nettype wire

// ===== logic/fpc_controller.sv
// register front end and command sequencer of the flash programming controller
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.svh"
module fpc_controller
    import fpc_pkg::*;
#(
    parameter int FLASH_WORDS = 16384,
    parameter int APP_BYTES = 65536,
    parameter logic [31:0] MAKER_ID = 32'h0000_0055, // arbitrary value
    parameter logic [31:0] UNIQUE_ID0 = 32'h1111_1111, // arbitrary value
    parameter logic [31:0] UNIQUE_ID1 = 32'h2222_2222, // arbitrary value
    parameter logic [31:0] UNIQUE_ID2 = 32'h3333_3333 // arbitrary value
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] reg_address,
    input wire logic [31:0] reg_write_data,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_read_data,
    input wire logic key_write,
    input wire logic [7:0] key_byte,
    output logic protect_unlocked,
    input wire logic cold_reset,
    input wire logic [1:0] boot_select_cfg,
    input wire logic running_from_loader,
    output logic flash_request,
    output logic [1:0] flash_op,
    output logic [31:0] flash_address,
    output logic [31:0] flash_write_data,
    input wire logic flash_done,
    input wire logic [31:0] flash_read_data,
    output logic [11:0] vector_remap_page,
    output logic low_freq_optimisation
);
    // the array holds at most 16K words and the application region must fit in it
    if (FLASH_WORDS < 1 || FLASH_WORDS > 16384
        || APP_BYTES > FLASH_WORDS * 4) begin : g_size_check
        $error("fpc_controller: flash size out of range");
    end
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_PROG = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h2;

    function automatic fpc_region_e region_of(input logic [31:0] a);
        // data flash counts as application space for the self-write check
        if (a < 32'(APP_BYTES) || (a >= `FPC_DF_BASE && a < `FPC_DF_END)) begin
            return FPC_REG_APP;
        end else if (a >= `FPC_LD_BASE && a < `FPC_LD_END) begin
            return FPC_REG_LOADER;
        end else if (a >= `FPC_CFG_BASE && a < `FPC_CFG_END) begin
            return FPC_REG_CONFIG;
        end
        return FPC_REG_NONE;
    endfunction

    // control, trigger and access-time bits
    logic fail_q;
    logic loader_upd_q;
    logic config_upd_q;
    logic app_upd_q;
    logic boot_q;
    logic en_q;
    logic go_q;
    logic low_freq_q;

    // operation registers
    logic [31:0] addr_q;
    logic [31:0] data_q;
    logic [5:0] cmd_q;
    logic [11:0] remap_q;
    logic [31:0] rdata_q;

    // sequencer
    logic req_q;
    logic [1:0] op_q;
    logic boot_loaded_q;
    fpc_state_e state_q;
    fpc_state_e state_d;

    // two-flop synchronisers, first and second stage
    logic [1:0] cfg_s1_q;
    logic [1:0] cfg_s2_q;
    logic cold_s1_q;
    logic cold_s2_q;
    logic run_s1_q;
    logic run_s2_q;
    logic done_s1_q;
    logic done_s2_q;

    wire logic unlocked;
    wire logic any_access = reg_write || reg_read;
    fpc_unlock u_unlock (
        .clock(clock),
        .reset(reset),
        .key_write(key_write),
        .key_byte(key_byte),
        .other_access(any_access),
        .unlocked(unlocked)
    );


    // bus decode on the full byte offset; a misaligned offset reads as unmapped
    wire logic wr_ctrl = reg_write && reg_address == `FPC_OFS_CONTROL;
    wire logic wr_addr = reg_write && reg_address == `FPC_OFS_ADDRESS;
    wire logic wr_data = reg_write && reg_address == `FPC_OFS_DATA;
    wire logic wr_cmd = reg_write && reg_address == `FPC_OFS_COMMAND;
    wire logic wr_trig = reg_write && reg_address == `FPC_OFS_TRIGGER;
    wire logic wr_acc = reg_write && reg_address == `FPC_OFS_ACCESS;
    wire logic wr_stat = reg_write && reg_address == `FPC_OFS_STATUS;
    wire logic prot_ok = unlocked;
    wire logic wr_ctrl_p = wr_ctrl && prot_ok;
    // fail flag is clearable through control or status bit 6
    wire logic fail_clear = prot_ok && ((wr_ctrl && reg_write_data[`FPC_BIT_FAIL])
                            || (wr_stat && reg_write_data[`FPC_BIT_FAIL]));
    // a trigger while busy is ignored, not queued; software polls the busy bit
    wire logic go_start = wr_trig && prot_ok && reg_write_data[`FPC_BIT_GO] && !go_q;


    // request checking
    wire fpc_region_e tgt_region = region_of(addr_q);
    wire fpc_region_e run_region = run_s2_q ? FPC_REG_LOADER : FPC_REG_APP;
    wire logic cmd_is_write = cmd_q == `FPC_CMD_PROG || cmd_q == `FPC_CMD_ERASE;
    wire logic cmd_known = cmd_is_write || cmd_q == `FPC_CMD_REMAP || cmd_q == `FPC_CMD_READ
                           || cmd_q == `FPC_CMD_UID || cmd_q == `FPC_CMD_MID;
    // the running region comes from the pin, not from boot select, which names the next boot
    wire logic err_app_self = cmd_is_write && tgt_region == FPC_REG_APP
                              && run_region == FPC_REG_APP && !app_upd_q;
    wire logic err_ld_self = cmd_is_write && tgt_region == FPC_REG_LOADER
                             && (run_region == FPC_REG_LOADER || !loader_upd_q);
    wire logic err_cfg = cmd_is_write && tgt_region == FPC_REG_CONFIG
                         && !config_upd_q;
    wire logic err_range = (cmd_q == `FPC_CMD_READ || cmd_is_write) && tgt_region == FPC_REG_NONE
                           || (cmd_q == `FPC_CMD_REMAP
                               && (tgt_region == FPC_REG_NONE || tgt_region == FPC_REG_CONFIG))
                           || !cmd_known;
    // disabled function refuses any operation as well
    wire logic any_error = err_app_self || err_ld_self || err_cfg || err_range || !en_q;

    // id and remap commands finish inside the block and never touch the array
    wire logic needs_flash = cmd_q == `FPC_CMD_READ || cmd_is_write;
    wire logic [1:0] uid_sel = addr_q[3:2];
    wire logic [31:0] uid_word = uid_sel == 2'h0 ? UNIQUE_ID0 :
                                 uid_sel == 2'h1 ? UNIQUE_ID1 : UNIQUE_ID2;
    wire logic [1:0] op_of_cmd = cmd_q == `FPC_CMD_PROG ? OP_PROG :
                                 cmd_q == `FPC_CMD_ERASE ? OP_ERASE : OP_READ;

    // a command of the given code accepted in the cycle the sequencer checks it
    function automatic logic accepted(input logic [5:0] c);
        return state_q == FPC_CHECK && !any_error && cmd_q == c;
    endfunction


    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FPC_IDLE: begin
                if (go_start) begin
                    state_d = FPC_CHECK;
                end
            end
            FPC_CHECK: begin
                // an error never reaches the flash
                if (!any_error && needs_flash) begin
                    state_d = FPC_WAIT;
                end else begin
                    state_d = FPC_IDLE;
                end
            end
            FPC_WAIT: begin
                if (done_s2_q) begin
                    state_d = FPC_IDLE;
                end
            end
            default: begin
                state_d = FPC_IDLE;
            end
        endcase
    end

    // pin synchronisers run through reset, so the boot load sees settled values
    always_ff @(posedge clock) begin
        cfg_s1_q <= boot_select_cfg;
        cfg_s2_q <= cfg_s1_q;
        cold_s1_q <= cold_reset;
        cold_s2_q <= cold_s1_q;
        run_s1_q <= running_from_loader;
        run_s2_q <= run_s1_q;
    end

    // done is cleared by reset so that no stale completion survives it
    always_ff @(posedge clock) begin
        if (reset) begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
        end else begin
            done_s1_q <= flash_done;
            done_s2_q <= done_s1_q;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= FPC_IDLE;
            go_q <= 1'b0;
            req_q <= 1'b0;
            op_q <= OP_READ;
        end else begin
            state_q <= state_d;
            // busy until the sequence returns to idle
            go_q <= go_start || (go_q && state_d != FPC_IDLE);
            req_q <= state_q == FPC_CHECK && state_d == FPC_WAIT;
            if (state_q == FPC_CHECK) begin
                op_q <= op_of_cmd;
            end
        end
    end

    // boot select is loaded once after a cold reset release; warm resets keep it
    always_ff @(posedge clock) begin
        if (reset) begin
            boot_loaded_q <= 1'b0;
        end else begin
            boot_loaded_q <= 1'b1;
        end
    end

    // fail flag: set beats clear when both land in one cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            fail_q <= 1'b0;
        end else if (state_q == FPC_CHECK && any_error) begin
            fail_q <= 1'b1;
        end else if (fail_clear) begin
            fail_q <= 1'b0;
        end
    end

    // enables change only through an unlocked control write
    always_ff @(posedge clock) begin
        if (reset) begin
            loader_upd_q <= 1'b0;
            config_upd_q <= 1'b0;
            app_upd_q <= 1'b0;
            en_q <= 1'b0;
        end else if (wr_ctrl_p) begin
            loader_upd_q <= reg_write_data[`FPC_BIT_LOADER_UPD];
            config_upd_q <= reg_write_data[`FPC_BIT_CONFIG_UPD];
            app_upd_q <= reg_write_data[`FPC_BIT_APP_UPD];
            en_q <= reg_write_data[`FPC_BIT_EN];
        end
    end

    // the access-time bit only tunes the array's read timing; nothing here depends on it
    always_ff @(posedge clock) begin
        if (reset) begin
            low_freq_q <= 1'b0;
        end else if (wr_acc && prot_ok) begin
            low_freq_q <= reg_write_data[`FPC_BIT_LOW_FREQ];
        end
    end

    // boot select is not cleared by reset; it holds the source of the next boot, not the running one
    always_ff @(posedge clock) begin
        if (!boot_loaded_q && cold_s2_q) begin
            boot_q <= ~cfg_s2_q[0];
        end else if (wr_ctrl_p) begin
            boot_q <= reg_write_data[`FPC_BIT_BOOT];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            addr_q <= 32'h0000_0000;
            data_q <= 32'h0000_0000;
            cmd_q <= 6'h00;
            remap_q <= 12'h000;
        end else begin
            if (wr_addr) begin
                addr_q <= reg_write_data;
            end
            if (state_q == FPC_WAIT && done_s2_q && op_q == OP_READ) begin
                data_q <= flash_read_data;
            end else if (accepted(`FPC_CMD_UID)) begin
                data_q <= uid_word;
            end else if (accepted(`FPC_CMD_MID)) begin
                data_q <= MAKER_ID;
            end else if (wr_data && !go_q) begin
                data_q <= reg_write_data;
            end
            if (wr_cmd) begin
                cmd_q <= reg_write_data[5:0];
            end
            if (accepted(`FPC_CMD_REMAP)) begin
                remap_q <= addr_q[20:`FPC_PAGE_LSB];
            end
        end
    end

    // read mux; reserved bits and unmapped offsets return zero
    wire logic [31:0] ctrl_view = {25'h0, fail_q, loader_upd_q, config_upd_q, app_upd_q,
                                   1'b0, boot_q, en_q};
    wire logic [31:0] stat_view = {11'h0, remap_q, 2'h0, fail_q, 3'h0, cfg_s2_q, go_q};
    wire logic [31:0] rd_mux = reg_address == `FPC_OFS_CONTROL ? ctrl_view :
                               reg_address == `FPC_OFS_ADDRESS ? addr_q :
                               reg_address == `FPC_OFS_DATA ? data_q :
                               reg_address == `FPC_OFS_COMMAND ? {26'h0, cmd_q} :
                               reg_address == `FPC_OFS_TRIGGER ? {31'h0, go_q} :
                               reg_address == `FPC_OFS_DFBASE ? `FPC_DF_BASE :
                               reg_address == `FPC_OFS_ACCESS ? {27'h0, low_freq_q, 4'h0} :
                               reg_address == `FPC_OFS_STATUS ? stat_view : 32'h0000_0000;
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_read) begin
            rdata_q <= rd_mux;
        end
    end

    assign reg_read_data = rdata_q;
    assign protect_unlocked = unlocked;
    // one whole word per program request, aligned to the word
    assign flash_request = req_q;
    assign flash_op = op_q;
    assign flash_address = {addr_q[31:2], 2'b00};
    assign flash_write_data = data_q;
    assign vector_remap_page = remap_q;
    // the array reads this bit directly; it is held in a flop so it never glitches
    assign low_freq_optimisation = low_freq_q;
endmodule
`default_nettype wire

// ===== logic/fpc_pkg.sv
// types of the flash programming controller
package fpc_pkg;
    typedef enum logic [1:0] {FPC_IDLE, FPC_CHECK, FPC_WAIT} fpc_state_e;
    typedef enum logic [1:0] {
        FPC_REG_APP, FPC_REG_LOADER, FPC_REG_CONFIG, FPC_REG_NONE
    } fpc_region_e;
endpackage

// ===== logic/fpc_regs.svh
// register offsets, field positions and fixed values of the flash programming controller
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
`define FPC_OFS_CONTROL 8'h00
`define FPC_OFS_ADDRESS 8'h04
`define FPC_OFS_DATA 8'h08
`define FPC_OFS_COMMAND 8'h0C
`define FPC_OFS_TRIGGER 8'h10
`define FPC_OFS_DFBASE 8'h14
`define FPC_OFS_ACCESS 8'h18
`define FPC_OFS_STATUS 8'h40
`define FPC_BIT_FAIL 6
`define FPC_BIT_LOADER_UPD 5
`define FPC_BIT_CONFIG_UPD 4
`define FPC_BIT_APP_UPD 3
`define FPC_BIT_BOOT 1
`define FPC_BIT_EN 0
`define FPC_BIT_GO 0
`define FPC_BIT_LOW_FREQ 4
`define FPC_DF_BASE 32'h0001_F000
`define FPC_DF_END 32'h0002_0000
`define FPC_CMD_READ 6'h00
`define FPC_CMD_UID 6'h04
`define FPC_CMD_MID 6'h0B
`define FPC_CMD_PROG 6'h21
`define FPC_CMD_ERASE 6'h22
`define FPC_CMD_REMAP 6'h2E
`define FPC_KEY0 8'h59
`define FPC_KEY1 8'h16
`define FPC_KEY2 8'h88
`define FPC_LD_BASE 32'h0010_0000
`define FPC_LD_END 32'h0010_1000
`define FPC_CFG_BASE 32'h0030_0000
`define FPC_CFG_END 32'h0030_0008
`define FPC_PAGE_LSB 9
`endif

// ===== logic/fpc_unlock.sv
// protection unlock: three key bytes in a row open the protected bits
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.svh"
module fpc_unlock (
    input wire logic clock,
    input wire logic reset,
    input wire logic key_write,
    input wire logic [7:0] key_byte,
    input wire logic other_access,
    output logic unlocked
);
    logic [1:0] step_q;
    logic [1:0] step_d;
    logic open_q;
    logic open_d;
    wire logic k0 = key_byte == `FPC_KEY0;
    wire logic k1 = key_byte == `FPC_KEY1;
    wire logic k2 = key_byte == `FPC_KEY2;
    // any other access breaks the sequence
    assign step_d = other_access ? 2'h0 :
                    !key_write ? step_q :
                    (step_q == 2'h1 && k1) ? 2'h2 :
                    (step_q == 2'h2 && k2) ? 2'h3 :
                    k0 ? 2'h1 : 2'h0;
    // a key write of a byte that is none of the three key values locks again while open
    assign open_d = (key_write && step_q == 2'h2 && k2) ? 1'b1 :
                    (key_write && !(k0 || k1 || k2)) ? 1'b0 : open_q;
    always_ff @(posedge clock) begin
        if (reset) begin
            step_q <= 2'h0;
            open_q <= 1'b0;
        end else begin
            step_q <= step_d;
            open_q <= open_d;
        end
    end
    assign unlocked = open_q;
endmodule
`default_nettype wire
